// *** pad_cell.v ***
// pad_cell.v - one pad cell joining a package pad to fabric logic.
// assumes: fabric signals share REF_CLK; PAD_IN comes from a pin and is synchronised here;
// the pad wire itself is resolved outside from PAD_OUT and PAD_OE.
`timescale 1ns/1ps
`default_nettype none
`include "pad_cell_regs.vh"

// Function
// - input-only variant builds no output driver, multiplexer or output/three-state storage
// - input-only cells are at most a quarter of all cells
// - each of three paths owns two elements, flop or latch
// - pad goes through delay to direct output and input pair
// - output data lines go through multiplexer, optionally via storage pair
// - drive-control lines through multiplexer decide when pad floats
// - every entering signal except GLOBAL_PRESET and the neighbour pair has an optional in-cell inversion
// - dual-edge pair turns rising-edge data into both-edge bits
// - flop captures on active edge only while enabled
// - open latch output follows its data input
// - unconnected clock enable acts as always asserted
// - set/reset forces selected level, sync or async per option
// - reverse forces opposite level under the same timing option
// - set/reset and reverse together give zero
// - output dual-edge pair can be shared with neighbouring cell
// - output/tri uppers share a clock, lowers another; inputs independent
// - one enable line per path drives both its elements
// - one set/reset and one reverse line drive all six elements
// - preset loads start value, default follows force polarity; configuration reset loads zero
module pad_cell #(
  parameter INPUT_ONLY = 0,
  parameter DLY_W = 3
) (
  input wire REF_CLK,
  input wire RST,
  input wire PAD_IN,
  output wire PAD_OUT,
  output wire PAD_OE,
  output reg PAD_DIRECT,
  output wire INPUT_REG_UPPER_OUT,
  output wire INPUT_REG_LOWER_OUT,
  input wire OUT_DATA_UPPER,
  input wire OUT_DATA_LOWER,
  input wire DRIVE_CTL_UPPER,
  input wire DRIVE_CTL_LOWER,
  input wire OUT_UPPER_CLOCK,
  input wire OUT_LOWER_CLOCK,
  input wire IN_UPPER_CAPTURE_CLOCK,
  input wire IN_LOWER_CAPTURE_CLOCK,
  input wire OUT_PATH_ENABLE,
  input wire TRISTATE_PATH_ENABLE,
  input wire IN_PATH_ENABLE,
  input wire SET_RESET_IN,
  input wire OPPOSITE_FORCE_IN,
  input wire GLOBAL_PRESET,
  input wire [`INV_W-1:0] INV_SEL,
  input wire [`NPATH-1:0] ENABLE_USED,
  input wire [`NELEM-1:0] LATCH_MODE,
  input wire [`NELEM-1:0] FORCE_HIGH_SEL,
  input wire [`NELEM-1:0] FORCE_TIMING_SEL,
  input wire [`NELEM-1:0] INIT_EXPLICIT,
  input wire [`NELEM-1:0] START_HIGH,
  input wire [DLY_W-1:0] IN_DELAY_TAPS,
  input wire OUT_REG_SEL,
  input wire OUT_DUAL_EDGE,
  input wire TRI_REG_SEL,
  input wire TRI_DUAL_EDGE,
  input wire SHARE_NB,
  input wire NB_UPPER_Q,
  input wire NB_LOWER_Q,
  output wire DUAL_UPPER_Q,
  output wire DUAL_LOWER_Q
);

  localparam DLY_N = 1 << DLY_W;

  // selects the value a path mux drives toward the pad
  function path_mux;
    input reg_sel;
    input dual;
    input clk_hi;
    input direct;
    input qu;
    input ql;
    begin
      if (!reg_sel) begin
        path_mux = direct;
      end else if (dual) begin
        path_mux = clk_hi ? qu : ql;
      end else begin
        path_mux = qu;
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pad input synchroniser; first stage feeds only the second
  reg pad_meta_r;
  reg pad_sync_r;

  always @(posedge REF_CLK) begin
    if (RST) begin
      pad_meta_r <= `ZERO1;
      pad_sync_r <= `ZERO1;
    end else begin
      pad_meta_r <= PAD_IN;
      pad_sync_r <= pad_meta_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // in-cell inversion
  wire [`INV_W-1:0] raw;
  wire [`INV_W-1:0] sig;

  assign raw[`B_PAD] = pad_sync_r;
  assign raw[`B_OUT_UP] = OUT_DATA_UPPER;
  assign raw[`B_OUT_LO] = OUT_DATA_LOWER;
  assign raw[`B_DRV_UP] = DRIVE_CTL_UPPER;
  assign raw[`B_DRV_LO] = DRIVE_CTL_LOWER;
  assign raw[`B_OCLK_UP] = OUT_UPPER_CLOCK;
  assign raw[`B_OCLK_LO] = OUT_LOWER_CLOCK;
  assign raw[`B_ICLK_UP] = IN_UPPER_CAPTURE_CLOCK;
  assign raw[`B_ICLK_LO] = IN_LOWER_CAPTURE_CLOCK;
  assign raw[`B_OEN] = OUT_PATH_ENABLE;
  assign raw[`B_TEN] = TRISTATE_PATH_ENABLE;
  assign raw[`B_IEN] = IN_PATH_ENABLE;
  assign raw[`B_SR] = SET_RESET_IN;
  assign raw[`B_REV] = OPPOSITE_FORCE_IN;
  assign sig = raw ^ INV_SEL;

  //////////////////////////////////////////////////////////////////////////////
  // programmable input delay line; tap zero is the synchronised pad
  reg [DLY_N-1:0] dly_r;
  wire pad_dly;

  always @(posedge REF_CLK) begin
    if (RST) begin
      dly_r <= {DLY_N{`ZERO1}};
    end else begin
      dly_r <= {dly_r[DLY_N-2:0], sig[`B_PAD]};
    end
  end

  assign pad_dly = (IN_DELAY_TAPS == {DLY_W{1'b0}}) ? sig[`B_PAD] : dly_r[IN_DELAY_TAPS - 1'b1];

  always @(posedge REF_CLK) begin
    if (RST) begin
      PAD_DIRECT <= `ZERO1;
    end else begin
      PAD_DIRECT <= pad_dly;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // per-element wiring
  wire [`NELEM-1:0] e_clk;
  wire [`NELEM-1:0] e_ce;
  wire [`NELEM-1:0] e_d;
  wire [`NELEM-1:0] e_fh;
  wire [`NELEM-1:0] e_q;
  wire [`NPATH-1:0] path_en;

  assign path_en[`P_IN] = ENABLE_USED[`P_IN] ? sig[`B_IEN] : 1'b1;
  assign path_en[`P_OUT] = ENABLE_USED[`P_OUT] ? sig[`B_OEN] : 1'b1;
  assign path_en[`P_TRI] = ENABLE_USED[`P_TRI] ? sig[`B_TEN] : 1'b1;

  assign e_clk[`E_IN_UP] = sig[`B_ICLK_UP];
  assign e_clk[`E_IN_LO] = sig[`B_ICLK_LO];
  assign e_clk[`E_OUT_UP] = sig[`B_OCLK_UP];
  assign e_clk[`E_TRI_UP] = sig[`B_OCLK_UP];
  assign e_clk[`E_OUT_LO] = sig[`B_OCLK_LO];
  assign e_clk[`E_TRI_LO] = sig[`B_OCLK_LO];

  assign e_ce[`E_IN_UP] = path_en[`P_IN];
  assign e_ce[`E_IN_LO] = path_en[`P_IN];
  assign e_ce[`E_OUT_UP] = path_en[`P_OUT];
  assign e_ce[`E_OUT_LO] = path_en[`P_OUT];
  assign e_ce[`E_TRI_UP] = path_en[`P_TRI];
  assign e_ce[`E_TRI_LO] = path_en[`P_TRI];

  assign e_d[`E_IN_UP] = pad_dly;
  assign e_d[`E_IN_LO] = pad_dly;
  assign e_d[`E_OUT_UP] = sig[`B_OUT_UP];
  assign e_d[`E_OUT_LO] = sig[`B_OUT_LO];
  assign e_d[`E_TRI_UP] = sig[`B_DRV_UP];
  assign e_d[`E_TRI_LO] = sig[`B_DRV_LO];

  // in dual-edge use the upper element's force polarity governs both
  assign e_fh[`E_IN_UP] = FORCE_HIGH_SEL[`E_IN_UP];
  assign e_fh[`E_IN_LO] = FORCE_HIGH_SEL[`E_IN_LO];
  assign e_fh[`E_OUT_UP] = FORCE_HIGH_SEL[`E_OUT_UP];
  assign e_fh[`E_OUT_LO] = OUT_DUAL_EDGE ? FORCE_HIGH_SEL[`E_OUT_UP] : FORCE_HIGH_SEL[`E_OUT_LO];
  assign e_fh[`E_TRI_UP] = FORCE_HIGH_SEL[`E_TRI_UP];
  assign e_fh[`E_TRI_LO] = TRI_DUAL_EDGE ? FORCE_HIGH_SEL[`E_TRI_UP] : FORCE_HIGH_SEL[`E_TRI_LO];

  //////////////////////////////////////////////////////////////////////////////
  // six storage elements; input-only cells build the input pair only
  genvar k;
  generate
    for (k = 0; k < `NELEM; k = k + 1) begin : g_elem
      if (INPUT_ONLY != 0 && k > `E_IN_LO) begin : g_none
        assign e_q[k] = 1'b0;
      end else begin : g_make
        wire init_v;
        assign init_v = INIT_EXPLICIT[k] ? START_HIGH[k] : e_fh[k];
        storage_elem u_elem (
          .clk(REF_CLK),
          .rst(RST),
          .clk_lvl(e_clk[k]),
          .ce(e_ce[k]),
          .d(e_d[k]),
          .sr(sig[`B_SR]),
          .opposite_force_in(sig[`B_REV]),
          .latch_mode(LATCH_MODE[k]),
          .force_high(e_fh[k]),
          .async_force(FORCE_TIMING_SEL[k]),
          .init_val(init_v),
          .gpreset(GLOBAL_PRESET),
          .q(e_q[k])
        );
      end
    end
  endgenerate

  assign INPUT_REG_UPPER_OUT = e_q[`E_IN_UP];
  assign INPUT_REG_LOWER_OUT = e_q[`E_IN_LO];

  //////////////////////////////////////////////////////////////////////////////
  // output and three-state multiplexers and pad driver
  generate
    if (INPUT_ONLY != 0) begin : g_in_only
      assign PAD_OUT = 1'b0;
      assign PAD_OE = 1'b0;
      assign DUAL_UPPER_Q = 1'b0;
      assign DUAL_LOWER_Q = 1'b0;
    end else begin : g_full
      wire out_qu;
      wire out_ql;
      wire drive_float;
      assign DUAL_UPPER_Q = e_q[`E_OUT_UP];
      assign DUAL_LOWER_Q = e_q[`E_OUT_LO];
      assign out_qu = SHARE_NB ? NB_UPPER_Q : e_q[`E_OUT_UP];
      assign out_ql = SHARE_NB ? NB_LOWER_Q : e_q[`E_OUT_LO];
      assign PAD_OUT = path_mux(OUT_REG_SEL, OUT_DUAL_EDGE, sig[`B_OCLK_UP],
                                sig[`B_OUT_UP], out_qu, out_ql);
      // high-impedance decision; a high control floats the pad
      assign drive_float = path_mux(TRI_REG_SEL, TRI_DUAL_EDGE, sig[`B_OCLK_UP],
                                    sig[`B_DRV_UP], e_q[`E_TRI_UP], e_q[`E_TRI_LO]);
      assign PAD_OE = ~drive_float;
    end
  endgenerate

  // device count limit: a chip build instantiates this with INPUT_ONLY set
  // on no more than a quarter of its cells; one cell cannot see the total.

endmodule // pad_cell

`default_nettype wire

// *** pad_cell_chk.sv ***
// pad_cell_chk.sv - port assertions for the pad cell.
// assumes: bound into pad_cell; one clock, RST synchronous.
`timescale 1ns/1ps
`default_nettype none
`include "pad_cell_regs.vh"
module pad_cell_chk #(
  parameter INPUT_ONLY = 0,
  parameter DLY_W = 3
) (
  input wire REF_CLK,
  input wire RST,
  input wire PAD_IN,
  input wire PAD_OUT,
  input wire PAD_OE,
  input wire PAD_DIRECT,
  input wire OUT_DATA_UPPER,
  input wire DRIVE_CTL_UPPER,
  input wire OUT_UPPER_CLOCK,
  input wire OUT_PATH_ENABLE,
  input wire SET_RESET_IN,
  input wire OPPOSITE_FORCE_IN,
  input wire GLOBAL_PRESET,
  input wire [`INV_W-1:0] INV_SEL,
  input wire [`NPATH-1:0] ENABLE_USED,
  input wire [`NELEM-1:0] LATCH_MODE,
  input wire [`NELEM-1:0] FORCE_HIGH_SEL,
  input wire [`NELEM-1:0] FORCE_TIMING_SEL,
  input wire [`NELEM-1:0] INIT_EXPLICIT,
  input wire [`NELEM-1:0] START_HIGH,
  input wire [DLY_W-1:0] IN_DELAY_TAPS,
  input wire OUT_REG_SEL,
  input wire OUT_DUAL_EDGE,
  input wire TRI_REG_SEL,
  input wire SHARE_NB,
  input wire NB_UPPER_Q,
  input wire NB_LOWER_Q,
  input wire DUAL_UPPER_Q,
  input wire DUAL_LOWER_Q
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////
  // cycles since reset; the two-stage pad synchroniser and the PAD_DIRECT register need three to refill
  logic [1:0] age_r;
  always @(posedge REF_CLK) age_r <= RST ? 2'h0 : age_r + {1'h0, age_r != 2'h3};
  // registered single-rate output with no inversions in play
  wire sdr = INPUT_ONLY == 0 && INV_SEL[13:1] == 13'h0000 && OUT_REG_SEL && !OUT_DUAL_EDGE
    && !LATCH_MODE[2];
  wire calm = !SET_RESET_IN && !OPPOSITE_FORCE_IN;
  wire frc = sdr && FORCE_TIMING_SEL[2] && !GLOBAL_PRESET;
  sequence s_rise;
    sdr && calm && !GLOBAL_PRESET && $rose(OUT_UPPER_CLOCK);
  endsequence
  sequence s_preset;
    sdr && GLOBAL_PRESET ##1 sdr && calm;
  endsequence
  ////////////////////////////////////////
  // routes straight through the cell
  AST_PAD_DIRECT: assert property (age_r == 2'h3 && IN_DELAY_TAPS == 0 && !INV_SEL[0]
    |-> PAD_DIRECT == $past(PAD_IN, 3)) else $error("pad direct delay wrong");
  AST_OUT_DIRECT: assert property (INPUT_ONLY == 0 && !OUT_REG_SEL
    |-> PAD_OUT == (OUT_DATA_UPPER ^ INV_SEL[1])) else $error("direct output wrong");
  AST_OE_DIRECT: assert property (INPUT_ONLY == 0 && !TRI_REG_SEL
    |-> PAD_OE == !(DRIVE_CTL_UPPER ^ INV_SEL[3])) else $error("output enable wrong");
  // element capture, hold and forcing
  AST_CAPTURE: assert property (s_rise ##0 (OUT_PATH_ENABLE || !ENABLE_USED[1])
    |=> !(sdr && calm) || PAD_OUT == $past(OUT_DATA_UPPER)) else $error("capture missed");
  AST_HOLD: assert property (s_rise ##0 (!OUT_PATH_ENABLE && ENABLE_USED[1])
    |=> !(sdr && calm) || $stable(PAD_OUT)) else $error("disabled element changed");
  AST_FORCE_LEVEL: assert property (frc && (SET_RESET_IN ^ OPPOSITE_FORCE_IN)
    |-> PAD_OUT == (SET_RESET_IN == FORCE_HIGH_SEL[2])) else $error("force level wrong");
  AST_BOTH_ZERO: assert property (frc && SET_RESET_IN && OPPOSITE_FORCE_IN
    |-> !PAD_OUT) else $error("double force not zero");
  AST_PRESET: assert property (s_preset |-> PAD_OUT == ($past(INIT_EXPLICIT[2])
    ? $past(START_HIGH[2]) : $past(FORCE_HIGH_SEL[2]))) else $error("preset value wrong");
  // dual-edge selection follows the upper clock phase; a shared pair comes from the neighbour
  AST_DUAL_MUX: assert property (INPUT_ONLY == 0 && OUT_REG_SEL && OUT_DUAL_EDGE
    && !INV_SEL[5] && age_r != 2'h0 && $stable(OUT_UPPER_CLOCK)
    |-> PAD_OUT == (OUT_UPPER_CLOCK ? (SHARE_NB ? NB_UPPER_Q : DUAL_UPPER_Q)
    : (SHARE_NB ? NB_LOWER_Q : DUAL_LOWER_Q))) else $error("dual mux");
endmodule // pad_cell_chk
bind pad_cell pad_cell_chk #(.INPUT_ONLY(INPUT_ONLY), .DLY_W(DLY_W)) chk_i (
  .REF_CLK(REF_CLK), .RST(RST), .PAD_IN(PAD_IN), .PAD_OUT(PAD_OUT), .PAD_OE(PAD_OE),
  .PAD_DIRECT(PAD_DIRECT), .OUT_DATA_UPPER(OUT_DATA_UPPER), .DRIVE_CTL_UPPER(DRIVE_CTL_UPPER),
  .OUT_UPPER_CLOCK(OUT_UPPER_CLOCK), .OUT_PATH_ENABLE(OUT_PATH_ENABLE),
  .SET_RESET_IN(SET_RESET_IN), .OPPOSITE_FORCE_IN(OPPOSITE_FORCE_IN),
  .GLOBAL_PRESET(GLOBAL_PRESET), .INV_SEL(INV_SEL), .ENABLE_USED(ENABLE_USED),
  .LATCH_MODE(LATCH_MODE), .FORCE_HIGH_SEL(FORCE_HIGH_SEL),
  .FORCE_TIMING_SEL(FORCE_TIMING_SEL), .INIT_EXPLICIT(INIT_EXPLICIT),
  .START_HIGH(START_HIGH), .IN_DELAY_TAPS(IN_DELAY_TAPS), .OUT_REG_SEL(OUT_REG_SEL),
  .OUT_DUAL_EDGE(OUT_DUAL_EDGE), .TRI_REG_SEL(TRI_REG_SEL), .SHARE_NB(SHARE_NB),
  .NB_UPPER_Q(NB_UPPER_Q), .NB_LOWER_Q(NB_LOWER_Q),
  .DUAL_UPPER_Q(DUAL_UPPER_Q), .DUAL_LOWER_Q(DUAL_LOWER_Q));
`default_nettype wire

// *** pad_cell_regs.vh ***
// pad_cell_regs.vh - bit positions, element indices and widths of the pad cell.
// assumes: included by pad_cell.v and storage_elem.v by bare name.
`ifndef PAD_CELL_REGS_VH
`define PAD_CELL_REGS_VH

// positions in the per-signal inversion vector
`define INV_W 14
`define B_PAD 0
`define B_OUT_UP 1
`define B_OUT_LO 2
`define B_DRV_UP 3
`define B_DRV_LO 4
`define B_OCLK_UP 5
`define B_OCLK_LO 6
`define B_ICLK_UP 7
`define B_ICLK_LO 8
`define B_OEN 9
`define B_TEN 10
`define B_IEN 11
`define B_SR 12
`define B_REV 13

// storage element indices (upper/lower of input, output, three-state)
`define NELEM 6
`define E_IN_UP 0
`define E_IN_LO 1
`define E_OUT_UP 2
`define E_OUT_LO 3
`define E_TRI_UP 4
`define E_TRI_LO 5

// path index within the enable-used vector
`define NPATH 3
`define P_IN 0
`define P_OUT 1
`define P_TRI 2

// reset value of every single-bit register
`define ZERO1 1'h0

`endif

// *** pad_pin.sv ***
// pad_pin.sv - board pin model beside the pad cell.
// assumes: where cell drive and board drive overlap in the tests, the cell drive wins.
`timescale 1ns/1ps
`default_nettype none
module pad_pin (
  input wire logic clk,
  input wire logic drv,
  input wire logic val,
  input wire logic ext_en,
  input wire logic ext_val,
  output logic pin
);
  logic last_r = 1'h0;
  // no pull on this pin, so a floating pin toggles rather than holds
  always @(posedge clk) last_r <= pin;
  assign pin = drv ? val : (ext_en ? ext_val : !last_r);
endmodule // pad_pin
`default_nettype wire

// *** storage_elem.v ***
// storage_elem.v - one storage element: edge flop or level latch with force controls.
// assumes: every input is on REF_CLK's domain; path clock arrives as a sampled level.
`timescale 1ns/1ps
`default_nettype none
`include "pad_cell_regs.vh"

module storage_elem (
  input wire clk,
  input wire rst,
  input wire clk_lvl,
  input wire ce,
  input wire d,
  input wire sr,
  input wire opposite_force_in,
  input wire latch_mode,
  input wire force_high,
  input wire async_force,
  input wire init_val,
  input wire gpreset,
  output wire q
);

  reg state_r;
  reg state_nxt;
  reg clk_prev_r;
  wire clk_rise;
  wire active;
  wire force_act;
  wire force_val;
  wire transparent;

  //////////////////////////////////////////////////////////////////////////////
  // capture on edge, or while open in latch mode
  assign clk_rise = clk_lvl & ~clk_prev_r;
  assign transparent = latch_mode & clk_lvl & ce;
  assign active = latch_mode ? transparent : (clk_rise & ce);
  assign force_act = sr | opposite_force_in;
  assign force_val = (sr & opposite_force_in) ? 1'b0 : (sr ? force_high : ~force_high);

  // next state: preset, then force, then data
  always @* begin
    state_nxt = state_r;
    if (gpreset) begin
      state_nxt = init_val;
    end else if (force_act & (async_force | active)) begin
      state_nxt = force_val;
    end else if (active) begin
      state_nxt = d;
    end
  end

  // rst stands for end of configuration; it clears the state to zero, not to the start value
  always @(posedge clk) begin
    if (rst) begin
      state_r <= `ZERO1;
      clk_prev_r <= `ZERO1;
    end else begin
      state_r <= state_nxt;
      clk_prev_r <= clk_lvl;
    end
  end

  // async force and open latch show at once, not a cycle late
  assign q = (async_force & force_act) ? force_val : (transparent ? d : state_r);

endmodule // storage_elem

`default_nettype wire

// *** tb_pad_cell.sv ***
// tb_pad_cell.sv - self-checking bench for the pad cell.
// assumes: pad_cell, pad_pin and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_pad_cell;
  logic clk = 0, rst = 1, odu = 0, odl = 0, dcu = 0, ouc = 0, iuc = 0, olc = 0, ope = 1;
  logic tpe = 0, sr = 0, opposite_force_in = 0, gp = 0, ors = 0, ode = 0, trs = 0, snb = 0, nbu = 0;
  logic nbl = 0, xen = 0, xv = 0, ilc = 0, ipe = 0;
  logic [2:0] tap = 3'h0;
  logic [13:0] inv = 14'h0000;
  logic [2:0] eu = 3'h7;
  logic [5:0] lm = 6'h00, fh = 6'h00, ft = 6'h00, ie = 6'h00, sh = 6'h00;
  logic [15:0] tab = 16'hb5e8;
  wire pin, pout, poe, pdir, du, dl, iru, irl;
  int err_count = 0, num_checks = 0, cyc = 0;
  pad_pin pp (.clk(clk), .drv(poe), .val(pout), .ext_en(xen), .ext_val(xv), .pin(pin));
  pad_cell dut (.REF_CLK(clk), .RST(rst), .PAD_IN(pin), .PAD_OUT(pout), .PAD_OE(poe),
    .PAD_DIRECT(pdir), .INPUT_REG_UPPER_OUT(iru), .INPUT_REG_LOWER_OUT(irl),
    .OUT_DATA_UPPER(odu), .OUT_DATA_LOWER(odl), .DRIVE_CTL_UPPER(dcu),
    .DRIVE_CTL_LOWER(1'h0), .OUT_UPPER_CLOCK(ouc), .OUT_LOWER_CLOCK(olc),
    .IN_UPPER_CAPTURE_CLOCK(iuc), .IN_LOWER_CAPTURE_CLOCK(ilc), .OUT_PATH_ENABLE(ope),
    .TRISTATE_PATH_ENABLE(tpe), .IN_PATH_ENABLE(ipe), .SET_RESET_IN(sr),
    .OPPOSITE_FORCE_IN(opposite_force_in), .GLOBAL_PRESET(gp), .INV_SEL(inv), .ENABLE_USED(eu),
    .LATCH_MODE(lm), .FORCE_HIGH_SEL(fh), .FORCE_TIMING_SEL(ft), .INIT_EXPLICIT(ie),
    .START_HIGH(sh), .IN_DELAY_TAPS(tap), .OUT_REG_SEL(ors), .OUT_DUAL_EDGE(ode),
    .TRI_REG_SEL(trs), .TRI_DUAL_EDGE(1'h0), .SHARE_NB(snb), .NB_UPPER_Q(nbu),
    .NB_LOWER_Q(nbl), .DUAL_UPPER_Q(du), .DUAL_LOWER_Q(dl));
  ////////////////////////////////////////
  always #5 clk = !clk;
  // hang guard; the whole run needs about a hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      results();
    end
  end
  task go(input int n);
    repeat (n) @(posedge clk);
  endtask
  task chk(input string nm, input logic s, input logic e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, s);
    end
  endtask
  // one rise of a path clock (0 out upper, 1 out lower, 2 in upper, 3 in lower)
  task pulse(input int w);
    go(1);
    case (w)
      0: ouc <= 1'h1;
      1: olc <= 1'h1;
      2: iuc <= 1'h1;
      default: ilc <= 1'h1;
    endcase
    go(1);
    {ouc, olc, iuc, ilc} <= 4'h0;
    go(1);
  endtask
  task results;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    go(5);
    rst <= 1'h0;
    for (int i = 0; i < 4; i++) begin
      go(1);
      {odu, inv[1], dcu, xen, xv} <= {i[0], i[1], 2'h3, i[0]};
      go(3);
      #1 chk("pad_out", pout, 1'(i[0] ^ i[1]));
      chk("pad_oe", poe, 1'h0);
      chk("pad_direct", pdir, 1'(i[0]));
    end
    $display("test direct routes done");
    go(1);
    {inv, dcu, ors, odu} <= {14'h0000, 3'h3};
    pulse(0);
    #1 chk("capture", pout, 1'h1);
    go(1);
    {odu, ope} <= 2'h0;
    pulse(0);
    #1 chk("disabled", pout, 1'h1);
    go(1);
    eu <= 3'h5;
    pulse(0);
    #1 chk("enable unused", pout, 1'h0);
    $display("test capture done");
    go(1);
    ft <= 6'h04;
    for (int i = 0; i < 4; i++) begin
      go(1);
      {sr, opposite_force_in, fh[2]} <= tab[4 * (3 - i) + 1 +: 3];
      go(1);
      #1 chk("force", pout, tab[4 * (3 - i)]);
    end
    go(1);
    {sr, opposite_force_in, ie, sh, gp} <= {2'h0, 6'h04, 6'h04, 1'h1};
    go(1);
    gp <= 1'h0;
    #1 chk("preset explicit", pout, 1'h1);
    go(1);
    {ie, fh, gp} <= {12'h000, 1'h1};
    go(1);
    gp <= 1'h0;
    #1 chk("preset default", pout, 1'h0);
    $display("test force done");
    go(1);
    {ft, ode, odu, odl, ope} <= {6'h00, 4'hd};
    pulse(0);
    pulse(1);
    go(1);
    ouc <= 1'h1;
    go(2);
    #1 chk("dual high", pout, 1'h1);
    go(1);
    ouc <= 1'h0;
    go(2);
    #1 chk("dual low", pout, 1'h0);
    go(1);
    {snb, nbu, nbl} <= 3'h5;
    go(2);
    #1 chk("shared low", pout, 1'h1);
    chk("own upper", du, 1'h1);
    chk("own lower", dl, 1'h0);
    $display("test dual edge done");
    // input pair: the board drives the pin while the cell driver floats
    go(1);
    {dcu, xv, ipe} <= 3'h7;
    go(3);
    pulse(2);
    #1 chk("in upper", iru, 1'h1);
    chk("in lower idle", irl, 1'h0);
    go(1);
    ipe <= 1'h0;
    pulse(3);
    #1 chk("in lower disabled", irl, 1'h0);
    go(1);
    ipe <= 1'h1;
    pulse(3);
    #1 chk("in lower", irl, 1'h1);
    // upper input element as a latch: open follows the pad, shut holds
    go(1);
    {lm[0], iuc, xv} <= 3'h6;
    go(3);
    #1 chk("latch open", iru, 1'h0);
    go(1);
    {iuc, xv} <= 2'h1;
    go(3);
    #1 chk("latch shut", iru, 1'h0);
    // two extra delay taps push the pad edge two cycles later
    go(1);
    {tap, xv} <= 4'h4;
    go(4);
    #1 chk("delay early", pdir, 1'h1);
    go(1);
    #1 chk("delay late", pdir, 1'h0);
    $display("test input path done");
    // registered drive control, clocked by the shared upper output clock
    go(1);
    {trs, tpe} <= 2'h3;
    go(1);
    #1 chk("oe before capture", poe, 1'h1);
    pulse(0);
    #1 chk("oe registered", poe, 1'h0);
    $display("test three-state done");
    results();
  end
endmodule // tb_pad_cell
`default_nettype wire
